// *** logic/iopcd_pin_cell.sv ***
`timescale 1ns/1ps
module iopcd_pin_cell #(
	parameter bit OD_CAP = 1'b0,
	parameter bit SLEW_CAP = 1'b0,
	parameter bit MODE_CAP = 1'b0,
	parameter logic [7:0] MASK = 8'hFF
) (
	// configuration
	input wire iopcd_pkg::iopcd_cfg_t cfg,
	input wire iopcd_pkg::iopcd_ovr_t ovr,
	// output sources
	input wire logic [7:0] pld_oe,
	input wire logic [7:0] addr_byte,
	// pad side
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] fast_slew
);

	logic [7:0] addr_mode;
	logic [7:0] value;
	logic [7:0] enable;
	logic [7:0] open_drain;

	always_comb begin
		addr_mode = MODE_CAP ? (cfg.mode & cfg.dir) : 8'h00;
		value = (addr_mode & addr_byte) | (~addr_mode & cfg.dout);
		enable = (cfg.dir | pld_oe) & MASK;
		open_drain = OD_CAP ? (cfg.drv & MASK) : 8'h00;
		fast_slew = SLEW_CAP ? cfg.drv : 8'h00;
		// open drain only ever pulls low; pull-up is external
		// override is per pin, so neighbours keep their own data
		pin_out = (ovr.en & ovr.val) | (~ovr.en & value & ~open_drain);
		pin_oe = enable & (~open_drain | ~value);
		pin_oe = ovr.en | (pin_oe & ~ovr.block);
	end

endmodule // iopcd_pin_cell

// *** logic/iopcd_pkg.sv ***
package iopcd_pkg;

	// port geometry
	localparam int NPORT = 7;
	localparam int PW = 8;
	localparam int AW = 6;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam int PORT_D = 3;
	localparam int PORT_E = 4;
	localparam int PORT_F = 5;
	localparam int PORT_G = 6;
	localparam logic [2:0] PORT_NONE = 3'h7;

	// register address: {reg_type[5:3], port[2:0]}
	localparam int RT_LSB = 3;
	localparam logic [2:0] RT_DATA_IN = 3'h0;
	localparam logic [2:0] RT_DATA_OUT = 3'h1;
	localparam logic [2:0] RT_DIRECTION = 3'h2;
	localparam logic [2:0] RT_DRIVER = 3'h3;
	localparam logic [2:0] RT_MODE = 3'h4;

	// reset values and masks
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] FULL_MASK = 8'hFF;
	localparam logic [7:0] PORTD_MASK = 8'h0F;

	// per-port capabilities, bit index is the port index
	localparam logic [6:0] OD_CAP = 7'h5B;
	localparam logic [6:0] SLEW_CAP = 7'h04;
	localparam logic [6:0] MODE_CAP = 7'h70;
	localparam logic [6:0] PLD_OUT_CAP = 7'h07;

	// dedicated pin positions
	localparam int PD_STROBE = 0;
	localparam int PD_CLOCK = 1;
	localparam int PD_SELECT_N = 2;
	localparam int PD_BYTE_EN = 3;
	localparam int PE_BATT_IN = 6;
	localparam int PE_BATT_ON = 7;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] dir;
		logic [7:0] drv;
		logic [7:0] dout;
	} iopcd_cfg_t;

	typedef struct packed {
		logic [7:0] en;
		logic [7:0] val;
		logic [7:0] block;
	} iopcd_ovr_t;

endpackage

// *** logic/iopcd_port_top.sv ***
`timescale 1ns/1ps
// Operation
// - direction bit 1 output, 0 input
// - all pins inputs after reset
// - port D direction uses low four bits
// - drive bit 1 selects open drain
// - drivers push-pull after reset
// - drive bit 1 selects fast slew
// - slew pins slow after reset
// - open drain A,B,D,E,G; slew on C
// - port F always push-pull
// - data-in reads live pins, read only
// - data-out driven when direction or pld enable
// - data-out reads back last write
// - port D bits 0,1 strobe and clock
// - high select disables memories and registers
// - test-port pins of E unavailable otherwise
// - port E bit 7 battery-on output
// - port F carries host data in data mode
// - ports A,B high address latched by strobe
// - port E outputs latched low address
// - mode bit 1 selects address out
// - configuration registers reset to zero
module iopcd_port_top (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// host register access
	input wire logic host_sel,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [5:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rdata_valid,
	// multiplexed host address byte
	input wire logic [7:0] host_ad_in,
	// static configuration
	input wire logic [3:0] pd_dedicated,
	input wire logic [7:0] jtag_pins,
	input wire logic batt_on_enable,
	input wire logic vcc_below_vbat,
	input wire logic data_port_mode,
	// logic array output enables for ports A, B, C
	input wire logic [2:0][7:0] pld_oe,
	// pads
	input wire logic [6:0][7:0] pin_in,
	output logic [6:0][7:0] pin_out,
	output logic [6:0][7:0] pin_oe,
	output logic [7:0] portc_fast_slew,
	// dedicated functions
	output logic address_strobe,
	output logic logic_array_clock_input,
	output logic data_byte_enable_input,
	output logic chip_selected,
	output logic flash_en,
	output logic sram_en,
	output logic io_register_space_select,
	output logic [7:0] latched_addr_low,
	output logic [15:0] latched_addr_high,
	// data port
	input wire logic [7:0] host_data_to_pins,
	input wire logic host_data_drive,
	output logic [7:0] host_data_from_pins
);

	iopcd_pkg::iopcd_cfg_t cfg [iopcd_pkg::NPORT];
	iopcd_pkg::iopcd_cfg_t next_cfg [iopcd_pkg::NPORT];
	iopcd_pkg::iopcd_ovr_t ovr [iopcd_pkg::NPORT];
	logic [7:0] pld_vec [iopcd_pkg::NPORT];
	logic [7:0] next_host_rdata;
	logic next_host_rdata_valid;
	logic [7:0] next_latched_addr_low;
	logic [15:0] next_latched_addr_high;
	logic [2:0] hport;
	logic [2:0] hrt;
	logic io_access;
	logic [7:0] port_mask;
	logic [7:0] read_mux;
	logic [6:0][7:0] fast_slew_all;

	assign hport = host_addr[iopcd_pkg::RT_LSB-1:0];
	assign hrt = host_addr[iopcd_pkg::AW-1:iopcd_pkg::RT_LSB];

	assign address_strobe = pd_dedicated[iopcd_pkg::PD_STROBE]
		& pin_in[iopcd_pkg::PORT_D][iopcd_pkg::PD_STROBE];
	assign logic_array_clock_input = pd_dedicated[iopcd_pkg::PD_CLOCK]
		& pin_in[iopcd_pkg::PORT_D][iopcd_pkg::PD_CLOCK];
	assign data_byte_enable_input = pd_dedicated[iopcd_pkg::PD_BYTE_EN]
		& pin_in[iopcd_pkg::PORT_D][iopcd_pkg::PD_BYTE_EN];

	assign chip_selected = !(pd_dedicated[iopcd_pkg::PD_SELECT_N]
		& pin_in[iopcd_pkg::PORT_D][iopcd_pkg::PD_SELECT_N]);
	assign flash_en = chip_selected;
	assign sram_en = chip_selected;
	assign io_register_space_select = host_sel & chip_selected;
	assign io_access = io_register_space_select && (hport != iopcd_pkg::PORT_NONE);

	assign host_data_from_pins = data_port_mode ? pin_in[iopcd_pkg::PORT_F] : 8'h00;
	assign portc_fast_slew = fast_slew_all[iopcd_pkg::PORT_C];

	// port D upper bits do not exist
	assign port_mask = (hport == 3'(iopcd_pkg::PORT_D)) ? iopcd_pkg::PORTD_MASK
		: iopcd_pkg::FULL_MASK;

	// read path
	always_comb begin
		read_mux = 8'h00;
		if (hport != iopcd_pkg::PORT_NONE) begin
			case (hrt)
				iopcd_pkg::RT_DATA_IN: begin
					read_mux = pin_in[hport] & port_mask;
					if (hport == 3'(iopcd_pkg::PORT_E)) begin
						read_mux = read_mux & ~jtag_pins;
					end
				end
				iopcd_pkg::RT_DATA_OUT: read_mux = cfg[hport].dout & port_mask;
				iopcd_pkg::RT_DIRECTION: read_mux = cfg[hport].dir;
				iopcd_pkg::RT_DRIVER: read_mux = cfg[hport].drv;
				iopcd_pkg::RT_MODE: read_mux = cfg[hport].mode;
				default: read_mux = 8'h00;
			endcase
		end
	end

	// register file and address latch next values
	always_comb begin
		for (int p = 0; p < iopcd_pkg::NPORT; p++) begin
			next_cfg[p] = cfg[p];
		end
		next_host_rdata = host_rdata;
		next_host_rdata_valid = 1'b0;
		next_latched_addr_low = latched_addr_low;
		next_latched_addr_high = latched_addr_high;
		if (io_access && host_wr) begin
			case (hrt)
				iopcd_pkg::RT_DATA_OUT: next_cfg[hport].dout = host_wdata & port_mask;
				// four bit direction on port D
				iopcd_pkg::RT_DIRECTION: next_cfg[hport].dir = host_wdata & port_mask;
				iopcd_pkg::RT_DRIVER: begin
					if (hport != 3'(iopcd_pkg::PORT_F)) begin
						next_cfg[hport].drv = host_wdata & port_mask;
					end
				end
				// mode only on E, F, G
				iopcd_pkg::RT_MODE: begin
					if (iopcd_pkg::MODE_CAP[hport]) begin
						next_cfg[hport].mode = host_wdata;
					end
				end
				// data-in and unmapped writes are dropped
				default: next_cfg[hport].dout = cfg[hport].dout;
			endcase
		end
		if (io_register_space_select && host_rd) begin
			next_host_rdata_valid = 1'b1;
			next_host_rdata = read_mux;
		end
		if (address_strobe) begin
			next_latched_addr_low = host_ad_in;
			next_latched_addr_high = {pin_in[iopcd_pkg::PORT_B], pin_in[iopcd_pkg::PORT_A]};
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int p = 0; p < iopcd_pkg::NPORT; p++) begin
				cfg[p] <= '{iopcd_pkg::CFG_RESET, iopcd_pkg::CFG_RESET,
					iopcd_pkg::CFG_RESET, iopcd_pkg::CFG_RESET};
			end
			host_rdata <= 8'h00;
			host_rdata_valid <= 1'b0;
			latched_addr_low <= 8'h00;
			latched_addr_high <= 16'h0000;
		end else begin
			for (int p = 0; p < iopcd_pkg::NPORT; p++) begin
				cfg[p] <= next_cfg[p];
			end
			host_rdata <= next_host_rdata;
			host_rdata_valid <= next_host_rdata_valid;
			latched_addr_low <= next_latched_addr_low;
			latched_addr_high <= next_latched_addr_high;
		end
	end

	// special pin ownership per port
	always_comb begin
		for (int p = 0; p < iopcd_pkg::NPORT; p++) begin
			ovr[p] = '{8'h00, 8'h00, 8'h00};
			pld_vec[p] = 8'h00;
		end
		// pld enables trusted on A, B, C only
		for (int p = 0; p < 3; p++) begin
			pld_vec[p] = pld_oe[p];
		end
		// dedicated port D pins are inputs only
		ovr[iopcd_pkg::PORT_D].block = {4'h0, pd_dedicated};
		ovr[iopcd_pkg::PORT_E].block = jtag_pins;
		if (batt_on_enable) begin
			ovr[iopcd_pkg::PORT_E].block[iopcd_pkg::PE_BATT_IN] = 1'b1;
			ovr[iopcd_pkg::PORT_E].en[iopcd_pkg::PE_BATT_ON] = 1'b1;
			ovr[iopcd_pkg::PORT_E].val[iopcd_pkg::PE_BATT_ON] = vcc_below_vbat;
		end
		// data port takes all of port F
		if (data_port_mode) begin
			ovr[iopcd_pkg::PORT_F].block = 8'hFF;
			ovr[iopcd_pkg::PORT_F].en = {8{host_data_drive}};
			ovr[iopcd_pkg::PORT_F].val = host_data_to_pins;
		end
	end

	// port F built without open drain
	for (genvar g = 0; g < iopcd_pkg::NPORT; g++) begin : g_port
		iopcd_pin_cell #(
			.OD_CAP(iopcd_pkg::OD_CAP[g]),
			.SLEW_CAP(iopcd_pkg::SLEW_CAP[g]),
			.MODE_CAP(iopcd_pkg::MODE_CAP[g]),
			.MASK((g == iopcd_pkg::PORT_D) ? iopcd_pkg::PORTD_MASK : iopcd_pkg::FULL_MASK)
		) u_cell (
			.cfg(cfg[g]),
			.ovr(ovr[g]),
			.pld_oe(pld_vec[g]),
			.addr_byte(latched_addr_low),
			.pin_out(pin_out[g]),
			.pin_oe(pin_oe[g]),
			.fast_slew(fast_slew_all[g])
		);
	end

	// helper: first cycle after reset release
	logic after_rst;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			after_rst <= 1'b1;
		end else begin
			after_rst <= 1'b0;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	a_dir_sets_oe: assert property (
		(cfg[iopcd_pkg::PORT_B].drv == 8'h00 && pld_oe[iopcd_pkg::PORT_B] == 8'h00)
		|-> pin_oe[iopcd_pkg::PORT_B] == cfg[iopcd_pkg::PORT_B].dir)
		else $error("port B enable differs from direction");

	a_reset_all_input: assert property (
		after_rst && pld_oe == '0 |-> pin_oe[iopcd_pkg::PORT_A] == 8'h00
		&& pin_oe[iopcd_pkg::PORT_C] == 8'h00 && portc_fast_slew == 8'h00)
		else $error("pin driven right after reset");

	a_reset_cfg_zero: assert property (
		after_rst |-> cfg[iopcd_pkg::PORT_G] == '0 && cfg[iopcd_pkg::PORT_D] == '0)
		else $error("configuration not cleared by reset");

	a_portd_upper_zero: assert property (
		io_access && host_wr && hrt == iopcd_pkg::RT_DIRECTION
		&& hport == 3'(iopcd_pkg::PORT_D)
		|=> cfg[iopcd_pkg::PORT_D].dir == {4'h0, $past(host_wdata[3:0])})
		else $error("port D direction upper bits stored");

	a_open_drain_low: assert property (
		cfg[iopcd_pkg::PORT_A].drv[0] && cfg[iopcd_pkg::PORT_A].dir[0]
		|-> !pin_out[iopcd_pkg::PORT_A][0]
		&& pin_oe[iopcd_pkg::PORT_A][0] == !cfg[iopcd_pkg::PORT_A].dout[0])
		else $error("open drain pin drove high");

	a_slew_write: assert property (
		io_access && host_wr && hrt == iopcd_pkg::RT_DRIVER && hport == 3'(iopcd_pkg::PORT_C)
		|=> portc_fast_slew == $past(host_wdata))
		else $error("slew select did not follow write");

	a_portf_push_pull: assert property (
		!data_port_mode && cfg[iopcd_pkg::PORT_F].dir[0] && !cfg[iopcd_pkg::PORT_F].mode[0]
		|-> pin_oe[iopcd_pkg::PORT_F][0]
		&& pin_out[iopcd_pkg::PORT_F][0] == cfg[iopcd_pkg::PORT_F].dout[0])
		else $error("port F not push-pull");

	a_data_in_live: assert property (
		io_register_space_select && host_rd && hrt == iopcd_pkg::RT_DATA_IN
		&& hport == 3'(iopcd_pkg::PORT_A)
		|=> host_rdata_valid && host_rdata == $past(pin_in[iopcd_pkg::PORT_A]))
		else $error("data-in read wrong");

	a_dout_readback: assert property (
		io_access && host_wr && hrt == iopcd_pkg::RT_DATA_OUT && hport == 3'(iopcd_pkg::PORT_G)
		##1 !host_wr
		##1 io_register_space_select && host_rd && !host_wr
		&& host_addr == $past(host_addr, 2)
		|=> host_rdata == $past(host_wdata, 3))
		else $error("data-out readback wrong");

	a_select_blocks: assert property (
		pd_dedicated[iopcd_pkg::PD_SELECT_N] && pin_in[iopcd_pkg::PORT_D][iopcd_pkg::PD_SELECT_N]
		&& host_rd |-> !io_register_space_select && !flash_en ##1 !host_rdata_valid)
		else $error("deselected access answered");

	a_jtag_released: assert property (
		(pin_oe[iopcd_pkg::PORT_E] & jtag_pins) == 8'h00)
		else $error("test-port pin driven");

	a_addr_latch: assert property (
		address_strobe |=> latched_addr_low == $past(host_ad_in))
		else $error("low address not latched");

	c_dir_write: cover property (io_access && host_wr && hrt == iopcd_pkg::RT_DIRECTION);
	c_addr_out: cover property (cfg[iopcd_pkg::PORT_E].mode[0] && cfg[iopcd_pkg::PORT_E].dir[0]);
	c_data_port: cover property (data_port_mode && host_data_drive);

endmodule // iopcd_port_top

// *** tb/iopcd_host_model.sv ***
`timescale 1ns/1ps
module iopcd_host_model (
	// bus clock
	input wire logic clock,
	// register access
	output logic host_sel,
	output logic host_wr,
	output logic host_rd,
	output logic [5:0] host_addr,
	output logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic host_rdata_valid
);
	// no output on logic inputs
	// only the bench picks directions, also on ports A, B, C fed by pld_oe
	initial begin
		host_sel = 1'b0;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_addr = 6'h00;
		host_wdata = 8'h00;
	end

	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge clock);
		host_sel <= 1'b1;
		host_wr <= 1'b1;
		host_addr <= a;
		host_wdata <= v;
		@(posedge clock);
		host_sel <= 1'b0;
		host_wr <= 1'b0;
		// released bus shows the inverse, not stale data
		host_wdata <= ~v;
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] v, output bit ok);
		ok = 1'b0;
		v = 8'h00;
		@(posedge clock);
		host_sel <= 1'b1;
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge clock);
		host_sel <= 1'b0;
		host_rd <= 1'b0;
		host_addr <= ~a;
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if (host_rdata_valid === 1'b1) begin
				ok = 1'b1;
				v = host_rdata;
			end else begin
				@(posedge clock);
			end
		end
	endtask
endmodule // iopcd_host_model

// *** tb/iopcd_port_top_tb_top.sv ***
`timescale 1ns/1ps
module iopcd_port_top_tb_top;
	localparam logic [2:0] DI = iopcd_pkg::RT_DATA_IN;
	localparam logic [2:0] DO = iopcd_pkg::RT_DATA_OUT;
	localparam logic [2:0] DR = iopcd_pkg::RT_DIRECTION;
	localparam logic [2:0] DV = iopcd_pkg::RT_DRIVER;
	localparam logic [2:0] MO = iopcd_pkg::RT_MODE;
	logic clock, sys_rst, host_sel, host_wr, host_rd, host_rdata_valid;
	logic [5:0] host_addr;
	logic [7:0] host_wdata, host_rdata, host_ad_in, jtag_pins, portc_fast_slew;
	logic [7:0] latched_addr_low, host_data_to_pins, host_data_from_pins;
	logic [3:0] pd_dedicated;
	logic batt_on_enable, vcc_below_vbat, data_port_mode, host_data_drive;
	logic address_strobe, logic_array_clock_input, data_byte_enable_input;
	logic chip_selected, flash_en, sram_en, io_register_space_select;
	logic [2:0][7:0] pld_oe;
	logic [6:0][7:0] pin_in, pin_out, pin_oe;
	logic [15:0] latched_addr_high;
	int mismatches = 0;
	int n_compared = 0;

	iopcd_port_top uut (.clock, .sys_rst, .host_sel, .host_wr, .host_rd, .host_addr,
		.host_wdata, .host_rdata, .host_rdata_valid, .host_ad_in, .pd_dedicated,
		.jtag_pins, .batt_on_enable, .vcc_below_vbat, .data_port_mode, .pld_oe,
		.pin_in, .pin_out, .pin_oe, .portc_fast_slew, .address_strobe,
		.logic_array_clock_input, .data_byte_enable_input, .chip_selected,
		.flash_en, .sram_en, .io_register_space_select, .latched_addr_low,
		.latched_addr_high, .host_data_to_pins, .host_data_drive,
		.host_data_from_pins);
	iopcd_host_model host (.clock, .host_sel, .host_wr, .host_rd, .host_addr,
		.host_wdata, .host_rdata, .host_rdata_valid);

	function automatic logic [7:0] msk(input int p);
		return (p == 3) ? 8'h0F : 8'hFF;
	endfunction
	task automatic summarize();
		$display("mismatches %0d n_compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic st(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [2:0] t, input int p, input logic [7:0] v);
		host.wr({t, 3'(p)}, v);
	endtask
	task automatic rdc(input logic [2:0] t, input int p, input logic [7:0] e);
		logic [7:0] v;
		bit ok;
		host.rd({t, 3'(p)}, v, ok);
		if (!ok) begin
			mismatches++;
			summarize();
		end else begin
			chk(v, e);
		end
	endtask

	task automatic t_reset();
		for (int p = 0; p < 7; p++) begin
			chk(pin_oe[p], 8'h00); // all inputs
			for (int t = 1; t < 5; t++) rdc(3'(t), p, 8'h00); // cleared
		end
		chk(portc_fast_slew, 8'h00); // slow slew
	endtask

	task automatic t_dir();
		bit od;
		for (int p = 0; p < 7; p++) begin
			od = p inside {0, 1, 3, 4, 6};
			wr(DO, p, 8'hA5);
			rdc(DO, p, 8'hA5 & msk(p)); // read back
			wr(DR, p, 8'hFF);
			rdc(DR, p, msk(p)); // low four bits only on port D
			chk(pin_oe[p], msk(p)); // outputs
			chk(pin_out[p] & pin_oe[p], 8'hA5 & msk(p)); // data driven
			wr(DV, p, 8'hFF);
			rdc(DV, p, (p == 5) ? 8'h00 : msk(p)); // driver width
			chk(pin_oe[p], od ? 8'h5A & msk(p) : msk(p)); // drive kind
			chk(pin_out[p] & pin_oe[p], od ? 8'h00 : 8'hA5 & msk(p)); // pulls low
			if (p == 2) chk(portc_fast_slew, 8'hFF); // fast slew
			wr(DV, p, 8'h00);
			wr(DR, p, 8'h07);
			st(1);
			chk(pin_oe[p], 8'h07); // three low outputs
			wr(DR, p, 8'h00);
		end
	endtask

	task automatic t_din();
		for (int p = 0; p < 7; p++) begin
			@(posedge clock);
			pin_in[p] <= 8'h3C ^ 8'(p);
			wr(DI, p, 8'hFF);
			rdc(DI, p, (8'h3C ^ 8'(p)) & msk(p)); // live levels
		end
	endtask

	task automatic t_pld();
		@(posedge clock);
		pld_oe <= {8'h00, 8'h00, 8'h0F};
		st(1);
		chk(pin_oe[0], 8'h0F); // array enable
		chk(pin_out[0] & 8'h0F, 8'h05); // latch value
		@(posedge clock);
		pld_oe <= '0;
	endtask

	task automatic t_ded();
		logic [7:0] v;
		bit ok;
		@(posedge clock);
		pd_dedicated <= 4'hF;
		pin_in[3] <= 8'h07;
		host_ad_in <= 8'h5A;
		pin_in[0] <= 8'h12;
		pin_in[1] <= 8'h34;
		st(2);
		chk({address_strobe, logic_array_clock_input, data_byte_enable_input}, 3'h6);
		chk({chip_selected, flash_en, sram_en, io_register_space_select}, 4'h0);
		wr(DR, 0, 8'hFF);
		host.rd({DR, 3'h0}, v, ok);
		chk(ok, 1'b0); // deselected read unanswered
		chk(latched_addr_low, 8'h5A); // low byte
		chk(latched_addr_high, 16'h3412); // high address
		@(posedge clock);
		pin_in[3] <= 8'h00;
		host_ad_in <= 8'hC3;
		st(2);
		chk(latched_addr_low, 8'h5A); // held without strobe
		chk(chip_selected, 1'b1); // selected again
		rdc(DR, 0, 8'h00); // write ignored
		wr(MO, 4, 8'hFF);
		wr(DR, 4, 8'hFF);
		st(1);
		chk(pin_out[4] & pin_oe[4], 8'h5A); // address out
		wr(MO, 4, 8'h00);
		st(1);
		chk(pin_out[4] & pin_oe[4], 8'hA5); // host data
	endtask

	task automatic t_spec();
		@(posedge clock);
		pd_dedicated <= 4'h0;
		jtag_pins <= 8'h0F;
		pin_in[4] <= 8'hFF;
		st(1);
		chk(pin_oe[4] & 8'h0F, 8'h00); // test pins released
		rdc(DI, 4, 8'hF0); // test pins hidden
		@(posedge clock);
		batt_on_enable <= 1'b1;
		vcc_below_vbat <= 1'b1;
		st(1);
		chk({pin_oe[4][7], pin_out[4][7]}, 2'h3); // battery on
		chk(pin_out[4] & pin_oe[4], 8'hA0); // other pins keep data
		@(posedge clock);
		vcc_below_vbat <= 1'b0;
		data_port_mode <= 1'b1;
		host_data_to_pins <= 8'h96;
		host_data_drive <= 1'b1;
		pin_in[5] <= 8'h69;
		st(1);
		chk({pin_oe[4][7], pin_out[4][7]}, 2'h2); // supply good
		chk(pin_out[5] & pin_oe[5], 8'h96); // data to host pins
		chk(host_data_from_pins, 8'h69); // data from pins
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		sys_rst = 1'b1;
		host_ad_in = 8'h00;
		pd_dedicated = 4'h0;
		jtag_pins = 8'h00;
		batt_on_enable = 1'b0;
		vcc_below_vbat = 1'b0;
		data_port_mode = 1'b0;
		pld_oe = '0;
		pin_in = '0;
		host_data_to_pins = 8'h00;
		host_data_drive = 1'b0;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		st(1);
		t_reset();
		t_dir();
		t_din();
		t_pld();
		t_ded();
		t_spec();
		summarize();
	end
endmodule // iopcd_port_top_tb_top
